// [logic/ebc_bus_ctrl.sv]
// ==========================================================
// What this block does
// - Acked cycle takes at least three clocks
// - Drive address and transfer size at start
// - Insert wait clocks until any ack low
// - No termination means waiting forever
// - Bus error wins over halt
// - Monitor raises bus error after timeout
// - Word reads two bytes, byte one
// - Compare only bits above the block
// - Upper address bits copy bit nineteen
// - Boot select base zero, 512K block
// - Select needs every option condition met
// - Mode bit picks async or legacy_bus_clock sync
// - Byte-lane field gates select per port
// - Reset clears lanes, then general lanes load from gen_opt; boot lanes become 11
// - Direction field limits reads or writes
// - Strobe bit aligns select to AS/DS in async mode
// - Ack field picks internal ack wait in async mode
// - External ack inputs always honoured
// - First fetch from reset vector zero
`timescale 1ns/1ps
`include "ebc_defines.svh"
module ebc_bus_ctrl
    import ebc_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rst_b,
    input  wire logic                  ce,
    input  wire logic                  req,
    input  wire logic                  req_rd,
    input  wire logic                  req_word,
    input  wire logic [23:0]           req_addr,
    input  wire logic [15:0]           req_wdata,
    input  wire logic [1:0]            port_size_ack_b,
    input  wire logic                  bus_error_in_b,
    input  wire logic                  halt_b,
    input  wire logic [15:0]           data_in,
    input  wire logic                  monitor_enable,
    input  wire logic [1:0]            monitor_timeout_select,
    input  wire logic                  legacy_bus_clock_in,
    input  wire logic [3*13-1:0]       gen_base,
    input  wire logic [3*3-1:0]        gen_blk,
    input  wire logic [3*16-1:0]       gen_opt,
    input  wire logic                  opt_wr,
    input  wire logic [1:0]            opt_wr_sel,
    input  wire ebc_opt_t              opt_wr_data,
    input  wire logic                  boot_base_wr,
    input  wire ebc_base_t             boot_base_data,
    output logic                       output_clock,
    output logic                       busy,
    output logic                       done,
    output logic                       err,
    output logic [15:0]                rdata_q,
    output logic                       ack16_q,
    output logic [23:0]                addr_q,
    output logic [1:0]                 transfer_size_q,
    output logic                       rd_wr_q,
    output logic                       address_strobe_b_q,
    output logic                       data_strobe_b_q,
    output logic [15:0]                data_out_q,
    output logic                       data_oe_q,
    output logic [`EBC_NSEL-1:0]       select_b,
    output logic [23:0]                reset_vector
);
    // ==========================================================
    // Reset synchroniser
    logic       rs1_q;
    logic       rst_q_b;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rs1_q   <= 1'b0;
            rst_q_b <= 1'b0;
        end else begin
            rs1_q   <= 1'b1;
            rst_q_b <= rs1_q;
        end
    end

    assign output_clock = mclk;
    assign reset_vector = `EBC_RESET_VECTOR;

    // ==========================================================
    // Select option storage
    ebc_opt_t   opt_q [`EBC_NSEL];
    ebc_base_t  boot_base_q;
    logic       rel_q;
    always_ff @(posedge mclk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            for (int i = 0; i < `EBC_NSEL; i++) begin
                opt_q[i] <= 16'h0000;
            end
            rel_q <= 1'b0;
        end else if (ce) begin
            if (!rel_q) begin
                rel_q <= 1'b1;
                for (int i = 1; i < `EBC_NSEL; i++) begin
                    opt_q[i] <= gen_opt[(i-1)*16 +: 16];
                end
                opt_q[0] <= 16'h3801;
                opt_q[0][`EBC_OPT_BYTE_HI:`EBC_OPT_BYTE_LO] <= `EBC_BOOT_BYTE_REL;
            end else if (opt_wr) begin
                opt_q[opt_wr_sel] <= opt_wr_data;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            boot_base_q <= `EBC_BOOT_BASE_RST;
        end else if (ce && boot_base_wr) begin
            boot_base_q <= boot_base_data;
        end
    end

    // ==========================================================
    // Bus cycle state machine
    ebc_state_e st_q;
    logic [2:0] cyc_q;
    logic [6:0] mon_q;
    logic [6:0] mon_lim;
    logic [3:0] wait_q;
    logic [`EBC_NSEL-1:0] int_ack;
    logic       ack_any;
    logic       bus_error;
    logic       halt;
    logic       term;

    always_comb begin
        unique case (monitor_timeout_select)
            2'h0: mon_lim = `EBC_BM_T3;
            2'h1: mon_lim = `EBC_BM_T2;
            2'h2: mon_lim = `EBC_BM_T1;
            2'h3: mon_lim = `EBC_BM_T0;
        endcase
    end

    // External acks always count, even with internal ack on
    assign ack_any = (port_size_ack_b != 2'h3) || (|int_ack);
    assign bus_error    = !bus_error_in_b ||
                     (monitor_enable && mon_q >= mon_lim);
    assign halt    = !halt_b && !bus_error;
    // No terminator: stays in wait forever
    assign term    = bus_error || halt ||
                     (ack_any && cyc_q >= 3'(`EBC_MIN_CYCLES - 2'h1));

    always_ff @(posedge mclk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            st_q <= EBC_IDLE;
        end else if (ce) begin
            unique case (st_q)
                EBC_IDLE: if (req && rel_q) st_q <= EBC_ADDR;
                EBC_ADDR: st_q <= EBC_WAIT;
                EBC_WAIT: if (term) st_q <= EBC_DONE;
                EBC_DONE: st_q <= EBC_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            cyc_q  <= 3'h0;
            mon_q  <= 7'h00;
            wait_q <= 4'h0;
        end else if (ce) begin
            if (st_q == EBC_IDLE) begin
                cyc_q  <= 3'h0;
                mon_q  <= 7'h00;
                wait_q <= 4'h0;
            end else begin
                if (cyc_q != 3'h7) cyc_q <= cyc_q + 3'h1;
                if (mon_q != 7'h7F) mon_q <= mon_q + 7'h01;
                if (st_q == EBC_WAIT && wait_q != 4'hF) wait_q <= wait_q + 4'h1;
            end
        end
    end

    // ==========================================================
    // Pins; upper address copies bit 19
    always_ff @(posedge mclk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            addr_q          <= 24'h000000;
            transfer_size_q <= 2'h0;
            rd_wr_q         <= 1'b1;
            data_out_q      <= 16'h0000;
        end else if (ce && st_q == EBC_IDLE && req && rel_q) begin
            addr_q          <= {{4{req_addr[19]}}, req_addr[19:0]};
            transfer_size_q <= req_word ? `EBC_SIZ_WORD : `EBC_SIZ_BYTE;
            rd_wr_q         <= req_rd;
            data_out_q      <= req_wdata;
        end
    end

    // Drive data only while the strobe frames a write
    always_ff @(posedge mclk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            data_oe_q <= 1'b0;
        end else if (ce) begin
            data_oe_q <= !rd_wr_q && (st_q == EBC_ADDR || (st_q == EBC_WAIT && !term));
        end
    end

    always_ff @(posedge mclk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            address_strobe_b_q <= 1'b1;
            data_strobe_b_q    <= 1'b1;
        end else if (ce) begin
            address_strobe_b_q <= !(st_q == EBC_ADDR || (st_q == EBC_WAIT && !term));
            data_strobe_b_q    <= !(st_q == EBC_WAIT && !term);
        end
    end

    // Peripheral drives data then acks with port size
    always_ff @(posedge mclk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            rdata_q <= 16'h0000;
            ack16_q <= 1'b0;
        end else if (ce && st_q == EBC_WAIT && term && !bus_error && !halt) begin
            rdata_q <= data_in;
            ack16_q <= !port_size_ack_b[1];
        end
    end

    logic err_q;
    always_ff @(posedge mclk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            err_q <= 1'b0;
        end else if (ce && st_q == EBC_WAIT && term) begin
            err_q <= bus_error || halt;
        end
    end
    assign busy = st_q != EBC_IDLE;
    assign done = st_q == EBC_DONE;
    assign err  = done && err_q;

    // ==========================================================
    // Chip selects, boot select is index 0
    ebc_sel_if sif ();
    assign sif.addr     = addr_q;
    assign sif.rd       = rd_wr_q;
    assign sif.as_act   = st_q == EBC_WAIT || st_q == EBC_ADDR;
    assign sif.ds_act   = st_q == EBC_WAIT;
    assign sif.legacy_bus_clock     = legacy_bus_clock_in;
    assign sif.siz      = transfer_size_q;
    assign sif.wait_cnt = wait_q;

    for (genvar g = 0; g < `EBC_NSEL; g++) begin : g_sel
        ebc_chip_select u_sel (
            .mclk    (mclk),
            .rst_q_b (rst_q_b),
            .ce      (ce),
            .bus     (sif.sel),
            .base    (g == 0 ? boot_base_q : gen_base[(g == 0 ? 0 : g-1)*13 +: 13]),
            .blk     (g == 0 ? `EBC_BOOT_BLK_RST : gen_blk[(g == 0 ? 0 : g-1)*3 +: 3]),
            .opt     (opt_q[g]),
            .cs_b_q  (select_b[g]),
            .int_ack (int_ack[g])
        );
    end
endmodule

// [logic/ebc_defines.svh]
`ifndef EBC_DEFINES_SVH
`define EBC_DEFINES_SVH
// Bus cycle timing, in output-clock (mclk) cycles
`define EBC_MIN_CYCLES      2'h3
`define EBC_BM_T0           7'h08
`define EBC_BM_T1           7'h10
`define EBC_BM_T2           7'h20
`define EBC_BM_T3           7'h40
// Select reset and release values, and the reset vector
`define EBC_BOOT_BASE_RST   13'h0000
`define EBC_BOOT_BLK_RST    3'h7
`define EBC_BOOT_BYTE_REL   2'h3
`define EBC_GEN_BYTE_RST    2'h0
`define EBC_RESET_VECTOR    24'h000000
// Size codes
`define EBC_SIZ_BYTE        2'h1
`define EBC_SIZ_WORD        2'h2
// Field positions of a select option word
`define EBC_OPT_MODE        15
`define EBC_OPT_BYTE_HI     14
`define EBC_OPT_BYTE_LO     13
`define EBC_OPT_RW_HI       12
`define EBC_OPT_RW_LO       11
`define EBC_OPT_STROBE_TIMING_SELECT        10
`define EBC_OPT_ACK_HI      9
`define EBC_OPT_ACK_LO      6
`define EBC_OPT_PORT16      0
// Select count, boot select is index 0
`define EBC_NSEL            4
`endif

// [logic/ebc_pkg.sv]
package ebc_pkg;
    typedef enum logic [1:0] {EBC_IDLE, EBC_ADDR, EBC_WAIT, EBC_DONE} ebc_state_e;
    typedef logic [15:0] ebc_opt_t;
    typedef logic [12:0] ebc_base_t;
endpackage

// [logic/ebc_sel_if.sv]
`timescale 1ns/1ps
interface ebc_sel_if;
    import ebc_pkg::*;
    logic [23:0] addr;
    logic        rd;
    logic        as_act;
    logic        ds_act;
    logic        legacy_bus_clock;
    logic [1:0]  siz;
    logic [3:0]  wait_cnt;
    modport bus (output addr, rd, as_act, ds_act, legacy_bus_clock, siz, wait_cnt);
    modport sel (input addr, rd, as_act, ds_act, legacy_bus_clock, siz, wait_cnt);
endinterface

// [logic/ebc_chip_select.sv]
`timescale 1ns/1ps
`include "ebc_defines.svh"
module ebc_chip_select
    import ebc_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      rst_q_b,
    input  wire logic      ce,
    ebc_sel_if.sel         bus,
    input  wire ebc_base_t base,
    input  wire logic [2:0] blk,
    input  wire ebc_opt_t  opt,
    output logic           cs_b_q,
    output logic           int_ack
);
    logic [23:0] mask;
    logic        hit;
    logic        lane_ok;
    logic        dir_ok;
    logic        strobe_timing_select_ok;
    logic [1:0]  bsel;
    logic [1:0]  rwf;
    logic [3:0]  ackf;

    assign bsel = {opt[`EBC_OPT_BYTE_HI], opt[`EBC_OPT_BYTE_LO]};
    assign rwf  = {opt[`EBC_OPT_RW_HI], opt[`EBC_OPT_RW_LO]};
    assign ackf = opt[`EBC_OPT_ACK_HI:`EBC_OPT_ACK_LO];
    // Block 4K << blk, so the boot code 7 spans 512K
    assign mask = 24'hFFFFFF << (5'd12 + 5'(blk));
    assign hit  = ((bus.addr & mask) == ({base, 11'h000} & mask));

    // Byte lanes: 8-bit port any nonzero, 16-bit per lane
    always_comb begin
        if (!opt[`EBC_OPT_PORT16]) begin
            lane_ok = (bsel != 2'h0);
        end else begin
            unique case (bsel)
                2'h0: lane_ok = 1'b0;
                2'h1: lane_ok = !(bus.addr[0] == 1'b0 &&
                                  bus.siz == `EBC_SIZ_BYTE);
                2'h2: lane_ok = !(bus.addr[0] == 1'b1 &&
                                  bus.siz == `EBC_SIZ_BYTE);
                2'h3: lane_ok = 1'b1;
            endcase
        end
    end

    always_comb begin
        unique case (rwf)
            2'h0: dir_ok = 1'b0;
            2'h1: dir_ok = bus.rd;
            2'h2: dir_ok = !bus.rd;
            2'h3: dir_ok = 1'b1;
        endcase
    end

    // Sync mode ignores strobe timing and tracks legacy_bus_clock
    assign strobe_timing_select_ok = opt[`EBC_OPT_MODE] ? (bus.as_act && bus.legacy_bus_clock) :
                     (opt[`EBC_OPT_STROBE_TIMING_SELECT] ? bus.ds_act : bus.as_act);

    always_ff @(posedge mclk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            cs_b_q <= 1'b1;
        end else if (ce) begin
            cs_b_q <= !(hit && lane_ok && dir_ok && strobe_timing_select_ok);
        end
    end

    // Internal ack after ackf waits; 4'hF means external only
    assign int_ack = !cs_b_q && !opt[`EBC_OPT_MODE] && ackf != 4'hF &&
                     bus.wait_cnt >= ackf;
endmodule

// [verification/ebc_bus_ctrl_monitor.sv]
`timescale 1ns/1ps
`include "ebc_defines.svh"
module ebc_bus_ctrl_monitor (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic [1:0]  port_size_ack_b,
    input wire logic        bus_error_in_b,
    input wire logic        halt_b,
    input wire logic        monitor_enable,
    input wire logic [1:0]  monitor_timeout_select,
    input wire logic        done,
    input wire logic        err,
    input wire logic [23:0] addr_q,
    input wire logic [1:0]  transfer_size_q,
    input wire logic        rd_wr_q,
    input wire logic        address_strobe_b_q,
    input wire logic        data_strobe_b_q,
    input wire logic        data_oe_q,
    input wire logic [3:0]  select_b,
    input wire logic [23:0] reset_vector
);
    // ==========================================
    // Bus cycle checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    chk_min_cycle: assert property (
        done |-> !$past(address_strobe_b_q, 2) && !$past(data_strobe_b_q))
        else $error("cycle shorter than three clocks");
    chk_ack_ends: assert property (
        !data_strobe_b_q && port_size_ack_b != 2'h3 |-> ##[0:2] done)
        else $error("acknowledge did not end cycle");
    chk_no_term: assert property (
        !data_strobe_b_q && port_size_ack_b == 2'h3 && bus_error_in_b && halt_b
        && !monitor_enable && &select_b |=> !done)
        else $error("cycle ended without termination");
    chk_fault_abort: assert property (
        !data_strobe_b_q && !(bus_error_in_b && halt_b) |-> ##[0:2] (done && err))
        else $error("fault input did not abort");
    chk_mon_short: assert property (
        monitor_enable && monitor_timeout_select == 2'h3 && $fell(address_strobe_b_q)
        |-> (!done) [*5] ##[1:7] (done && err))
        else $error("monitor timeout off");
    chk_size_code: assert property (
        !address_strobe_b_q |-> transfer_size_q inside {`EBC_SIZ_BYTE, `EBC_SIZ_WORD})
        else $error("bad transfer size");
    chk_upper_copy: assert property (
        !address_strobe_b_q |-> addr_q[23:20] == {4{addr_q[19]}})
        else $error("upper address not mirrored");
    chk_wr_drive: assert property (
        data_oe_q |-> !address_strobe_b_q && !rd_wr_q)
        else $error("data driven outside write");
    chk_boot_match: assert property (
        !select_b[0] |-> !addr_q[19])
        else $error("boot select outside block");
    chk_gen_idle: assert property (
        select_b[3:1] == 3'h7)
        else $error("cleared select asserted");
    chk_reset_vec: assert property (
        reset_vector == `EBC_RESET_VECTOR)
        else $error("reset vector moved");
    cov_fault: cover property (done && err);
    cov_write: cover property (done && !err && !rd_wr_q);
    cov_boot: cover property ($fell(select_b[0]));
endmodule

// [verification/ebc_periph_model.sv]
`timescale 1ns/1ps
module ebc_periph_model (
    input  wire logic        mclk,
    input  wire logic        as_b,
    input  wire logic [23:0] addr,
    input  wire logic [2:0]  mode,
    input  wire logic [3:0]  dly,
    output logic      [1:0]  ack_b,
    output logic             bus_error_b,
    output logic             halt_b,
    output logic      [15:0] data
);
    // ==========================================
    // Answer dly clocks after address strobe
    logic [3:0] cnt_q;
    logic       go;
    always_ff @(posedge mclk) begin
        cnt_q <= as_b ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hF};
    end
    assign go = !as_b && cnt_q >= dly;
    // Mode 0 byte port, 1 and 2 word port, 3 silent
    assign ack_b = !go ? 2'h3 : mode == 3'h0 ? 2'h2 : mode == 3'h1 ? 2'h1 :
                   mode == 3'h2 ? 2'h0 : 2'h3;
    assign bus_error_b = !(go && (mode == 3'h4 || mode == 3'h5));
    assign halt_b = !(go && (mode == 3'h5 || mode == 3'h6));
    // Released bus shows the inverse so a stale value never matches
    assign data = (addr[15:0] ^ 16'h5AC3) ^ {16{!go}};
endmodule

// [verification/ebc_bus_ctrl_bench.sv]
`timescale 1ns/1ps
module ebc_bus_ctrl_bench;
    import ebc_pkg::*;
    logic        mclk = 1'b0, rst_b = 1'b0, legacy_bus_clock_in = 1'b0;
    logic        req = 1'b0, req_rd = 1'b0, req_word = 1'b0, opt_wr = 1'b0;
    logic        monitor_enable = 1'b0, done, busy, err, ack16_q, rd_wr_q;
    logic        address_strobe_b_q, data_strobe_b_q, data_oe_q, output_clock;
    logic        bus_error_in_b, halt_b, gd, ge;
    logic [1:0]  monitor_timeout_select = 2'h0, opt_wr_sel = 2'h0, transfer_size_q;
    logic [1:0]  port_size_ack_b, sz;
    logic [2:0]  p_mode = 3'h1;
    logic [3:0]  p_dly = 4'h0, select_b, sl;
    logic [15:0] req_wdata = 16'h0000, opt_wr_data = 16'h0000, seed = 16'h8CE1;
    logic [15:0] data_in, rdata_q, data_out_q, wdo, wexp;
    logic [23:0] req_addr = 24'h000000, addr_q, reset_vector, ad;
    logic [47:0] gen_opt = {3{16'h8CE1 & 16'h9FFF}};
    int          cyc, mismatches = 0, checked = 0;
    always #5 mclk = ~mclk;
    always #40 legacy_bus_clock_in = ~legacy_bus_clock_in;
    ebc_bus_ctrl dut (.mclk, .rst_b, .ce(1'b1), .req, .req_rd, .req_word, .req_addr,
        .req_wdata, .port_size_ack_b, .bus_error_in_b, .halt_b, .data_in, .monitor_enable,
        .monitor_timeout_select, .legacy_bus_clock_in, .gen_base(39'h0), .gen_blk(9'h0),
        .gen_opt, .opt_wr, .opt_wr_sel, .opt_wr_data, .boot_base_wr(1'b0),
        .boot_base_data(13'h0000), .output_clock, .busy, .done, .err, .rdata_q, .ack16_q,
        .addr_q, .transfer_size_q, .rd_wr_q, .address_strobe_b_q, .data_strobe_b_q,
        .data_out_q, .data_oe_q, .select_b, .reset_vector);
    ebc_periph_model u_per (.mclk, .as_b(address_strobe_b_q), .addr(addr_q), .mode(p_mode),
        .dly(p_dly), .ack_b(port_size_ack_b), .bus_error_b(bus_error_in_b), .halt_b,
        .data(data_in));
    // ==========================================
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic int ecyc(input logic [3:0] d);
        return (d > 4'h1 ? int'(d) + 2 : 3) + 1;
    endfunction
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [23:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_opt(input logic [15:0] v);
        @(posedge mclk);
        opt_wr <= 1'b1;
        opt_wr_data <= v;
        @(posedge mclk);
        opt_wr <= 1'b0;
    endtask
    // Hang allowed only where a silent bus is the point
    task automatic run(input logic [23:0] a, input logic r, w, input logic [2:0] m,
                       input logic [3:0] d, input int lim, input logic hang_ok);
        @(posedge mclk);
        seed = lfsr(seed);
        wexp = seed;
        {req, req_addr, req_rd, req_word, req_wdata, p_mode, p_dly} <= {1'b1, a, r, w, seed, m, d};
        {sl, gd, ge} = {4'h0, 2'b00};
        cyc = 1;
        @(posedge mclk);
        req <= 1'b0;
        while (!gd && cyc < lim) begin
            #1;
            if (!address_strobe_b_q) {sz, ad} = {transfer_size_q, addr_q};
            if (data_oe_q) wdo = data_out_q;
            sl = sl | ~select_b;
            {gd, ge} = {done === 1'b1, err === 1'b1};
            if (!gd) begin @(posedge mclk); cyc++; end
        end
        if (!gd && !hang_ok) begin mismatches++; give_verdict; end
        @(posedge mclk);
        #1;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        logic [23:0] a;
        logic [3:0]  d;
        logic        r, w;
        int          t;
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        check("idle_sel", select_b, 4'hF);
        run(24'h000000, 1'b1, 1'b1, 3'h1, 4'h0, 40, 1'b0);
        check("boot_sel", sl, 4'h1);
        wr_opt(16'h7BC1);
        for (int i = 0; i < 30; i++) begin
            seed = lfsr(seed);
            a[23:8] = seed;
            seed = lfsr(seed);
            {d, r, w, a[7:0]} = {1'b0, seed[12:8], seed[7:1], seed[0] & !seed[8]};
            run(a, r, w, {2'h0, w}, d, 40, 1'b0);
            check("cyc", cyc >= ecyc(d) && cyc <= ecyc(d) + 1, 1'b1);
            check("sel", sl, {3'h0, !a[19]});
            check("siz", sz, w ? 2'h2 : 2'h1);
            check("addr", ad, {{4{a[19]}}, a[19:0]});
            check("ack16", {ack16_q, ge}, {w, 1'b0});
            if (r && w) check("rdata", rdata_q, a[15:0] ^ 16'h5AC3);
            if (!r && w) check("wdata", wdo, wexp);
        end
        for (int m = 4; m < 7; m++) begin
            run(24'hF80000, 1'b1, 1'b1, m[2:0], 4'h1, 40, 1'b0);
            check("fault", ge, 1'b1);
        end
        for (int c = 0; c < 4; c++) begin
            @(posedge mclk);
            {monitor_enable, monitor_timeout_select} <= {1'b1, c[1:0]};
            run(24'hF80000, 1'b0, 1'b1, 3'h3, 4'h0, 90, 1'b0);
            check("mon", ge && cyc >= (64 >> c) && cyc <= (64 >> c) + 4, 1'b1);
        end
        @(posedge mclk);
        monitor_enable <= 1'b0;
        run(24'hF80000, 1'b1, 1'b0, 3'h3, 4'h0, 150, 1'b1);
        check("hang", {gd, busy}, 2'h1);
        p_mode <= 3'h4;
        for (t = 0; t < 20 && done !== 1'b1; t++) begin @(posedge mclk); #1; end
        if (done !== 1'b1) begin mismatches++; give_verdict; end
        for (int k = 0; k < 5; k++) begin
            wr_opt(k < 2 ? 16'h6BC1 : k == 2 ? 16'h1BC1 : k == 3 ? 16'h7801 : 16'h7A01);
            run(24'h000000, k > 0, 1'b1, k == 3 ? 3'h3 : 3'h1, 4'h0, 40, 1'b0);
            check("opt_sel", {sl[0], ge}, {k != 0 && k != 2, 1'b0});
            if (k == 4) check("ext_ack", cyc, 4);
        end
        give_verdict;
    end
endmodule
bind ebc_bus_ctrl ebc_bus_ctrl_monitor u_mon (.mclk, .rst_b, .port_size_ack_b,
    .bus_error_in_b, .halt_b, .monitor_enable, .monitor_timeout_select, .done, .err,
    .addr_q, .transfer_size_q, .rd_wr_q, .address_strobe_b_q, .data_strobe_b_q,
    .data_oe_q, .select_b, .reset_vector);
